/* File: bench/dac_link_asserts.sv */
// Link and status checks for the converter control ends
`timescale 1ns/1ps
`default_nettype none
module dac_link_asserts
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic wr_strobe,
	input wire logic reg_select_high,
	input wire logic reg_select_low,
	input wire logic [dac_pkg::ADDR_W-1:0] channel_address_field,
	input wire logic [dac_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_ready,
	input wire logic parallel_select,
	input wire logic over_temp_pin,
	input wire logic [dac_pkg::CTRL_W-1:0] control_word,
	input wire logic amps_powered_down,
	input wire logic fifo_active
);
	logic spec;
	logic guard;
	assign spec = wr_strobe && !reg_select_high && !reg_select_low;
	assign guard = control_word[dac_pkg::THERMAL_BIT];
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	a_ctrl_decode: assert property (
		spec && channel_address_field == dac_pkg::ADDR_CTRL && !fifo_active
		|=> control_word == $past(wr_data))
		else $error("control write lost");
	a_guard_gate: assert property (!guard |=> !amps_powered_down)
		else $error("shutdown with guard off");
	a_shutdown_on: assert property (
		(guard && over_temp_pin)[*4] |=> amps_powered_down)
		else $error("no shutdown when hot");
	a_shutdown_hold: assert property (
		amps_powered_down && guard && !fifo_active &&
		!(spec && channel_address_field == dac_pkg::ADDR_SOFT_PU)
		|=> amps_powered_down)
		else $error("shutdown released early");
	a_fifo_strap: assert property (fifo_active |-> parallel_select)
		else $error("queue without parallel port");
	a_fifo_frozen: assert property (
		$past(rstn, 3) |-> $stable(fifo_active))
		else $error("queue mode changed");
	a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
		else $error("long write strobe");
	a_write_gap: assert property (
		wr_strobe |=> (!wr_strobe)[*8] ##1 !wr_strobe)
		else $error("writes too close");
	a_ready_direct: assert property (
		!fifo_active && $past(rstn, 2) |-> wr_ready)
		else $error("ready low in direct mode");
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench joining controller end and converter end
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin \
	err_total++; $display("MISMATCH %0t %s", $time, m); end end
module tb;
	logic mclk, rstn, cmd_valid, cmd_alt, cmd_ready, load_req;
	logic parallel_mode, queue_mode, over_temp_pin;
	logic amps_powered_down, fifo_active;
	logic [1:0] cmd_reg_select;
	logic [5:0] cmd_addr;
	logic [15:0] cmd_data, control_word;
	logic [dac_pkg::NUM_CH-1:0][dac_pkg::CODE_W-1:0] dac_codes;
	logic [13:0] prim_e[40], alt_e[40];
	logic [39:0] sa;
	logic [4:0] en_e, fresh;
	logic [31:0] r;
	int err_total, check_count, seed;
	dac_link_if link();
	dac_ctrl_host u_dac_ctrl_host (.mclk(mclk), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_reg_select(cmd_reg_select),
		.cmd_addr(cmd_addr), .cmd_alt(cmd_alt), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .load_req(load_req),
		.parallel_mode(parallel_mode), .queue_mode(queue_mode), .link(link));
	dac_ctrl_device u_dac_ctrl_device (.mclk(mclk), .rstn(rstn),
		.over_temp_pin(over_temp_pin), .link(link), .dac_codes(dac_codes),
		.amps_powered_down(amps_powered_down), .fifo_active(fifo_active),
		.control_word(control_word));
	dac_link_asserts u_dac_link_asserts (.mclk(mclk), .rstn(rstn),
		.wr_strobe(link.wr_strobe), .reg_select_high(link.reg_select_high),
		.reg_select_low(link.reg_select_low),
		.channel_address_field(link.channel_address_field),
		.wr_data(link.wr_data), .wr_ready(link.wr_ready),
		.parallel_select(link.parallel_select),
		.over_temp_pin(over_temp_pin), .control_word(control_word),
		.amps_powered_down(amps_powered_down), .fifo_active(fifo_active));
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	function automatic logic [13:0] exp_code(input int c);
		return sa[c] ? alt_e[c] : prim_e[c];
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [1:0] s, input logic [5:0] a,
		input logic alt, input logic [15:0] d);
		int n = 0;
		@(negedge mclk);
		while (cmd_ready !== 1'b1 && n < 60)
		begin
			@(negedge mclk);
			n++;
		end
		`CHK(cmd_ready, 1'b1, "host not ready")
		cmd_reg_select = s;
		cmd_addr = a;
		cmd_alt = alt;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task automatic cw(input logic [15:0] d);
		wr(2'h0, dac_pkg::ADDR_CTRL, 1'b0, d);
		fresh = fresh | (d[6:2] & ~en_e);
		en_e = d[6:2];
		`CHK(control_word, d, "control word")
	endtask
	task automatic dw(input logic [5:0] ch, input logic alt,
		input logic [15:0] d);
		wr(2'h3, ch, alt, d);
		if (ch < 6'h28 && !alt)
			prim_e[ch] = d[13:0];
		if (ch < 6'h28 && alt && en_e[ch[5:3]])
			alt_e[ch] = d[13:0];
	endtask
	task automatic ld();
		@(negedge mclk);
		load_req = 1'b1;
		@(negedge mclk);
		load_req = 1'b0;
		repeat (3) @(negedge mclk);
		for (int c = 0; c < 40; c++)
			sa[c] = en_e[c / 8] && !fresh[c / 8] && !sa[c];
		fresh = 5'h00;
		for (int c = 0; c < 40; c++)
			`CHK(dac_codes[c], exp_code(c), "output code")
	endtask
	task automatic rst(input logic p, input logic q);
		@(negedge mclk);
		rstn = 1'b0;
		parallel_mode = p;
		queue_mode = q;
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		repeat (3) @(negedge mclk);
		prim_e = '{default: 14'h0000};
		alt_e = '{default: 14'h0000};
		sa = '0;
		en_e = 5'h00;
		fresh = 5'h00;
	endtask
	initial
	begin
		#200000;
		err_total++;
		close_out();
	end
	initial
	begin
		seed = 21926;
		err_total = 0;
		check_count = 0;
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_reg_select = 2'h0;
		cmd_addr = 6'h00;
		cmd_alt = 1'b0;
		cmd_data = 16'h0000;
		load_req = 1'b0;
		over_temp_pin = 1'b0;
		rst(1'b1, 1'b0);
		cw(16'h0004);
		dw(6'h03, 1'b0, 16'h1111);
		dw(6'h03, 1'b1, 16'h2222);
		dw(6'h08, 1'b1, 16'h3333);
		repeat (3) ld();
		cw(16'h0000);
		ld();
		$display("test toggle done");
		repeat (80)
		begin
			r = $random(seed);
			case (r[1:0])
				2'h0: cw(r[31:16] & 16'h007c);
				2'h1: ld();
				default: dw(r[7:2] < 6'h30 ? r[7:2] : 6'h27, r[9], r[31:16]);
			endcase
		end
		$display("test random done");
		cw(16'h0100);
		over_temp_pin = 1'b1;
		repeat (6) @(negedge mclk);
		`CHK(amps_powered_down, 1'b1, "no shutdown")
		over_temp_pin = 1'b0;
		repeat (6) @(negedge mclk);
		`CHK(amps_powered_down, 1'b1, "not latched")
		wr(2'h0, dac_pkg::ADDR_SOFT_PU, 1'b0, 16'h0000);
		`CHK(amps_powered_down, 1'b0, "soft power-up")
		over_temp_pin = 1'b1;
		repeat (6) @(negedge mclk);
		`CHK(amps_powered_down, 1'b1, "no second shutdown")
		wr(2'h0, dac_pkg::ADDR_SOFT_PU, 1'b0, 16'h0000);
		`CHK(amps_powered_down, 1'b1, "power-up while hot")
		cw(16'h0000);
		`CHK(amps_powered_down, 1'b0, "guard cleared")
		repeat (6) @(negedge mclk);
		`CHK(amps_powered_down, 1'b0, "guard off")
		over_temp_pin = 1'b0;
		$display("test thermal done");
		for (int i = 0; i < 4; i++)
		begin
			rst(i[1], i[0]);
			`CHK(fifo_active, i[1] & i[0], "queue strap")
		end
		queue_mode = 1'b0;
		wr(2'h0, dac_pkg::ADDR_CTRL, 1'b0, 16'h0100);
		`CHK(fifo_active, 1'b1, "queue latch")
		`CHK(control_word, 16'h0000, "queue early")
		repeat (95) @(negedge mclk);
		`CHK(control_word, 16'h0100, "queue late")
		for (int c = 0; c < 40; c++)
			dw(6'(c), 1'b0, 16'($random(seed)));
		// Last entry must land within the group time counted from the first
		repeat (3210) @(negedge mclk);
		ld();
		$display("test queue done");
		close_out();
	end
endmodule
`default_nettype wire

/* File: core/dac_ctrl_device.sv */
// Converter end: control word, toggle outputs, thermal guard, write queue
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_device
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic over_temp_pin,
	dac_link_if.device link,
	output logic [dac_pkg::NUM_CH-1:0][dac_pkg::CODE_W-1:0] dac_codes,
	output logic amps_powered_down,
	output logic fifo_active,
	output logic [dac_pkg::CTRL_W-1:0] control_word
);
	logic [dac_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [dac_pkg::NUM_CH-1:0][dac_pkg::CODE_W-1:0] prim_q, prim_d;
	logic [dac_pkg::NUM_CH-1:0][dac_pkg::CODE_W-1:0] alt_q, alt_d;
	logic [dac_pkg::NUM_CH-1:0][dac_pkg::CODE_W-1:0] dac_q, dac_d;
	logic [dac_pkg::NUM_CH-1:0] sel_q, sel_d;
	logic [dac_pkg::NUM_GROUPS-1:0] fresh_q, fresh_d;
	logic shutdown_q, shutdown_d;
	logic init_done_q, init_done_d;
	logic fifo_q, fifo_d;
	logic ready_q, ready_d;
	logic [dac_pkg::QUEUE_W-1:0] queue_mem [dac_pkg::NUM_CH];
	logic [dac_pkg::CNT_W-1:0] wr_ptr_q, wr_ptr_d;
	logic [dac_pkg::CNT_W-1:0] rd_ptr_q, rd_ptr_d;
	logic [dac_pkg::CNT_W-1:0] count_q, count_d;
	logic [dac_pkg::TIMER_W-1:0] timer_q, timer_d;
	logic temp_meta_q, temp_sync_q;
	logic push, drain, apply_en, soft_pu;
	logic [dac_pkg::QUEUE_W-1:0] link_word, apply_word;
	logic [1:0] a_rs;
	logic [dac_pkg::ADDR_W-1:0] a_addr;
	logic a_alt;
	logic [dac_pkg::DATA_W-1:0] a_data;
	logic [dac_pkg::NUM_GROUPS-1:0] tog_q;

	assign link_word = {link.reg_select_high, link.reg_select_low,
		link.channel_address_field, link.alt_select, link.wr_data};
	assign tog_q = ctrl_q[dac_pkg::TOGGLE_MSB:dac_pkg::TOGGLE_LSB];

	always_comb
	begin
		ctrl_d = ctrl_q;
		prim_d = prim_q;
		alt_d = alt_q;
		dac_d = dac_q;
		sel_d = sel_q;
		fresh_d = fresh_q;
		shutdown_d = shutdown_q;
		init_done_d = 1'b1;
		fifo_d = fifo_q;
		soft_pu = 1'b0;
		// Strap capture happens once, in the first cycle after reset
		if (!init_done_q)
			fifo_d = link.queue_enable && link.parallel_select;
		push = link.wr_strobe && fifo_q && ready_q;
		drain = (count_q != '0) &&
			(timer_q == dac_pkg::TIMER_W'(dac_pkg::CH_UPDATE_CYC - 1));
		apply_en = (link.wr_strobe && !fifo_q) || drain;
		apply_word = fifo_q ? queue_mem[rd_ptr_q] : link_word;
		{a_rs, a_addr, a_alt, a_data} = apply_word;
		if (apply_en)
		begin
			if (a_rs == dac_pkg::RS_SPECIAL)
			begin
				if (a_addr == dac_pkg::ADDR_CTRL)
					ctrl_d = a_data;
				else if (a_addr == dac_pkg::ADDR_SOFT_PU)
					soft_pu = 1'b1;
			end
			else if (a_rs == dac_pkg::RS_DATA &&
				a_addr < dac_pkg::ADDR_W'(dac_pkg::NUM_CH))
			begin
				if (!a_alt)
					prim_d[a_addr] = a_data[dac_pkg::CODE_W-1:0];
				else if (tog_q[dac_pkg::ch_group(int'(a_addr))])
					alt_d[a_addr] = a_data[dac_pkg::CODE_W-1:0];
			end
		end
		if (link.output_load_strobe)
		begin
			for (int ch = 0; ch < dac_pkg::NUM_CH; ch++)
			begin
				if (tog_q[dac_pkg::ch_group(ch)])
				begin
					if (fresh_q[dac_pkg::ch_group(ch)])
						sel_d[ch] = 1'b0;
					else
						sel_d[ch] = !sel_q[ch];
				end
				else
					sel_d[ch] = 1'b0;
				dac_d[ch] = sel_d[ch] ? alt_q[ch] : prim_q[ch];
			end
			fresh_d = '0;
		end
		// A group enabled in this cycle starts over from primary
		for (int g = 0; g < dac_pkg::NUM_GROUPS; g++)
		begin
			if (ctrl_d[dac_pkg::TOGGLE_LSB + g] && !tog_q[g])
				fresh_d[g] = 1'b1;
		end
		// Set outranks both ways of recovering
		if (ctrl_q[dac_pkg::THERMAL_BIT] && temp_sync_q)
			shutdown_d = 1'b1;
		else if (!ctrl_q[dac_pkg::THERMAL_BIT] || (soft_pu && !temp_sync_q))
			shutdown_d = 1'b0;
	end

	always_comb
	begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		timer_d = '0;
		if (push)
			wr_ptr_d = dac_pkg::ptr_inc(wr_ptr_q);
		if (drain)
			rd_ptr_d = dac_pkg::ptr_inc(rd_ptr_q);
		if (push && !drain)
			count_d = count_q + 6'h01;
		else if (drain && !push)
			count_d = count_q - 6'h01;
		if (count_q != '0 && !drain)
			timer_d = timer_q + 7'h01;
		ready_d = !fifo_d || (count_d < dac_pkg::CNT_W'(dac_pkg::NUM_CH));
	end

	always_ff @(posedge mclk)
	begin
		if (push)
			queue_mem[wr_ptr_q] <= link_word;
	end

	always_ff @(posedge mclk)
	begin
		temp_meta_q <= over_temp_pin;
		temp_sync_q <= temp_meta_q;
		if (!rstn)
		begin
			ctrl_q <= dac_pkg::CTRL_RESET;
			prim_q <= '{default: dac_pkg::CODE_RESET};
			alt_q <= '{default: dac_pkg::CODE_RESET};
			dac_q <= '{default: dac_pkg::CODE_RESET};
			sel_q <= '0;
			fresh_q <= '0;
			shutdown_q <= 1'b0;
			init_done_q <= 1'b0;
			fifo_q <= 1'b0;
			ready_q <= 1'b0;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			timer_q <= '0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			prim_q <= prim_d;
			alt_q <= alt_d;
			dac_q <= dac_d;
			sel_q <= sel_d;
			fresh_q <= fresh_d;
			shutdown_q <= shutdown_d;
			init_done_q <= init_done_d;
			fifo_q <= fifo_d;
			ready_q <= ready_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
			timer_q <= timer_d;
		end
	end

	assign dac_codes = dac_q;
	assign amps_powered_down = shutdown_q;
	assign fifo_active = fifo_q;
	assign control_word = ctrl_q;
	assign link.wr_ready = ready_q;
endmodule
`default_nettype wire

/* File: core/dac_ctrl_host.sv */
// Controller end: paces writes onto the link and forwards load strobes
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_host
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_reg_select,
	input wire logic [dac_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic cmd_alt,
	input wire logic [dac_pkg::DATA_W-1:0] cmd_data,
	output logic cmd_ready,
	input wire logic load_req,
	input wire logic parallel_mode,
	input wire logic queue_mode,
	dac_link_if.host link
);
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_GAP = 2'b10
	} host_state_type;

	host_state_type state_q, state_d;
	logic [dac_pkg::GAP_W-1:0] gap_q, gap_d;
	logic ready_q, ready_d;
	logic strobe_q, strobe_d;
	logic [1:0] rs_q, rs_d;
	logic [dac_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic alt_q, alt_d;
	logic [dac_pkg::DATA_W-1:0] data_q, data_d;
	logic load_q, par_q, queue_q;

	always_comb
	begin
		state_d = state_q;
		gap_d = gap_q;
		strobe_d = 1'b0;
		rs_d = rs_q;
		addr_d = addr_q;
		alt_d = alt_q;
		data_d = data_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (cmd_valid && ready_q)
				begin
					strobe_d = 1'b1;
					rs_d = cmd_reg_select;
					addr_d = cmd_addr;
					alt_d = cmd_alt;
					data_d = cmd_data;
					gap_d = dac_pkg::GAP_W'(dac_pkg::WRITE_CYCLE_CYC - 1);
					state_d = ST_GAP;
				end
			end
			ST_GAP:
			begin
				if (gap_q == 4'h1)
					state_d = ST_IDLE;
				gap_d = gap_q - 4'h1;
			end
			default:
				state_d = ST_IDLE;
		endcase
		ready_d = (state_d == ST_IDLE) && link.wr_ready && !strobe_d;
	end

	always_ff @(posedge mclk)
	begin
		// Straps follow their pins through reset so the far end latches them
		par_q <= parallel_mode;
		queue_q <= queue_mode;
		if (!rstn)
		begin
			state_q <= ST_IDLE;
			gap_q <= '0;
			ready_q <= 1'b0;
			strobe_q <= 1'b0;
			rs_q <= '0;
			addr_q <= '0;
			alt_q <= 1'b0;
			data_q <= '0;
			load_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			gap_q <= gap_d;
			ready_q <= ready_d;
			strobe_q <= strobe_d;
			rs_q <= rs_d;
			addr_q <= addr_d;
			alt_q <= alt_d;
			data_q <= data_d;
			load_q <= load_req;
		end
	end

	assign cmd_ready = ready_q;
	assign link.wr_strobe = strobe_q;
	assign link.reg_select_high = rs_q[1];
	assign link.reg_select_low = rs_q[0];
	assign link.channel_address_field = addr_q;
	assign link.alt_select = alt_q;
	assign link.wr_data = data_q;
	assign link.output_load_strobe = load_q;
	assign link.parallel_select = par_q;
	assign link.queue_enable = queue_q;
endmodule
`default_nettype wire

/* File: core/dac_link_if.sv */
// Parallel host link between controller and converter control logic
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
	logic wr_strobe;
	logic reg_select_high;
	logic reg_select_low;
	logic [dac_pkg::ADDR_W-1:0] channel_address_field;
	logic alt_select;
	logic [dac_pkg::DATA_W-1:0] wr_data;
	logic output_load_strobe;
	logic parallel_select;
	logic queue_enable;
	logic wr_ready;

	modport device
	(
		input wr_strobe, reg_select_high, reg_select_low,
		input channel_address_field, alt_select, wr_data,
		input output_load_strobe, parallel_select, queue_enable,
		output wr_ready
	);
	modport host
	(
		output wr_strobe, reg_select_high, reg_select_low,
		output channel_address_field, alt_select, wr_data,
		output output_load_strobe, parallel_select, queue_enable,
		input wr_ready
	);
endinterface
`default_nettype wire

/* File: core/dac_pkg.sv */
// Shared constants and helpers for the multichannel converter control link
package dac_pkg;
	localparam int NUM_CH = 40;
	localparam int GROUP_SIZE = 8;
	localparam int NUM_GROUPS = 5;
	localparam int CODE_W = 14;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 6;
	localparam int CTRL_W = 16;
	localparam int CNT_W = 6;
	localparam int QUEUE_W = 2 + ADDR_W + 1 + DATA_W;
	localparam logic [1:0] RS_SPECIAL = 2'h0;
	localparam logic [1:0] RS_DATA = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h0c;
	localparam logic [ADDR_W-1:0] ADDR_SOFT_PU = 6'h09;
	localparam int TOGGLE_LSB = 2;
	localparam int TOGGLE_MSB = 6;
	localparam int THERMAL_BIT = 8;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_CYCLE_NS = 40;
	localparam int GROUP_UPDATE_NS = 14400;
	// Least time rounds up
	localparam int WRITE_CYCLE_CYC =
		(WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest time rounds down
	localparam int GROUP_UPDATE_CYC = GROUP_UPDATE_NS / CLK_PERIOD_NS;
	localparam int CH_UPDATE_CYC = GROUP_UPDATE_CYC / NUM_CH;
	localparam int TIMER_W = 7;
	localparam int GAP_W = 4;

	function automatic int ch_group(input int ch);
		ch_group = ch / GROUP_SIZE;
	endfunction

	function automatic logic [CNT_W-1:0] ptr_inc(input logic [CNT_W-1:0] p);
		if (p == CNT_W'(NUM_CH - 1))
			ptr_inc = '0;
		else
			ptr_inc = p + 6'h01;
	endfunction
endpackage
